// ---- rtl/cpu_bus_interrupt_interface.sv ----
`timescale 1ns/100ps
// Contract
// - low address byte on bus in address phase
// - low bus carries data in phases two-four
// - address bits 15..8 on middle byte
// - middle byte floats while hold granted
// - 16-bit operand: low byte then high
// - low bus floats in hold and ack
// - NMI rising edge, unmaskable, five clocks
// - NMI serviced after current instruction ends
// - NMI routine from vector number 2
// - hold granted even during interrupt acknowledge
// - NMI, accepted INT, reset leave standby
// - INT level sampled in last instruction clock
// - INT accepted only with enable flag set
// - granting INT asserts acknowledge output; code asserts it in small mode only
// - NMI wins over simultaneous INT
// - reset high overrides everything
// - after reset fetch from FFFF0H
// - ready low inserts wait states
// - ready high in phase three ends waits
// - scale select held fixed; high small
// - small mode: acknowledge low, vector on bus
// - hold grant floats address, data, control
module cpu_bus_interrupt_interface (
    // clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 reset_in,
    // core side
    input  wire cpu_bus_pkg::bus_req_t req_in,
    input  wire logic                 instr_last_clk_in,
    input  wire logic                 irq_enable_flag_in,
    input  wire logic                 standby_req_in,
    output logic                      req_done_out,
    output logic [15:0]               rdata_out,
    output logic                      nmi_take_out,
    output logic                      int_take_out,
    output logic [7:0]                int_vector_out,
    output logic [19:0]               fetch_addr_out,
    output logic                      fetch_load_out,
    output logic                      standby_out,
    // pins
    input  wire logic [7:0]           addr_data_low_bus_in,
    output logic [7:0]                addr_data_low_bus_out,
    output logic                      addr_data_low_bus_oe_out,
    output logic [7:0]                addr_mid_byte_out,
    output logic                      addr_mid_byte_oe_out,
    output logic                      ctrl_oe_out,
    output logic                      write_out,
    input  wire logic                 ready_in,
    input  wire logic                 nmi_in,
    input  wire logic                 int_in,
    input  wire logic                 bus_hold_req_in,
    output logic                      bus_hold_grant_out,
    output logic                      irq_ack_n_out,
    input  wire logic                 system_scale_select_in
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cpu_bus_pkg::phase_t phase;     // current bus phase
        logic                second;    // high byte of a wide transfer
        logic                wide;      // latched width
        logic                write;     // latched direction
        logic                ack_cyc;   // interrupt-acknowledge cycle
        logic [19:0]         addr;      // latched address
        logic [15:0]         wdata;     // write operand
        logic [15:0]         rdata;     // read assembly
        logic                done;      // transfer finished pulse
        logic [1:0]          nmi_sync;  // nmi synchroniser
        logic                nmi_prev;  // last synchronised nmi
        logic [2:0]          nmi_cnt;   // high-time counter
        logic                nmi_pend;  // latched nmi request
        logic [1:0]          int_sync;  // int synchroniser
        logic [1:0]          rdy_sync;  // ready synchroniser
        logic [1:0]          hold_sync; // hold synchroniser
        logic [1:0]          sel_sync;  // scale select synchroniser
        logic                hold;      // hold granted
        logic                standby;   // standby mode
        logic                nmi_take;  // nmi service pulse
        logic                int_take;  // int accept pulse
        logic                ack_n;     // acknowledge pin
        logic [7:0]          vector;    // captured vector
        logic [19:0]         fetch;     // fetch address
        logic                fload;     // fetch load pulse
        logic                boot;      // first cycle after reset
        logic [7:0]          low_out;   // low bus value
        logic                low_oe;    // low bus enable
        logic [7:0]          mid_out;   // middle byte value
        logic                mid_oe;    // middle byte enable
    } state_t;

    state_t state_reg;
    state_t state_next;

    // byte of the operand for the current half
    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next          = state_reg;
        state_next.done     = 1'b0;
        state_next.nmi_take = 1'b0;
        state_next.int_take = 1'b0;
        state_next.fload    = 1'b0;
        state_next.boot     = 1'b0;

        // two-flop synchronisers on every pin input except the low bus, which is sampled directly
        state_next.nmi_sync  = {state_reg.nmi_sync[0], nmi_in};
        state_next.int_sync  = {state_reg.int_sync[0], int_in};
        state_next.rdy_sync  = {state_reg.rdy_sync[0], ready_in};
        state_next.hold_sync = {state_reg.hold_sync[0], bus_hold_req_in};
        state_next.sel_sync  = {state_reg.sel_sync[0], system_scale_select_in};
        state_next.nmi_prev  = state_reg.nmi_sync[1];

        // nmi counts high clocks after a rising edge; latched at five
        if (state_reg.nmi_sync[1] && !state_reg.nmi_prev) begin
            state_next.nmi_cnt = 3'd1;
        end else if (state_reg.nmi_sync[1] && state_reg.nmi_cnt != 3'd0) begin
            if (state_reg.nmi_cnt == 3'(cpu_bus_pkg::NMI_HOLD_CLKS - 1)) begin
                state_next.nmi_pend = 1'b1;
                state_next.nmi_cnt  = 3'd0;
            end else begin
                state_next.nmi_cnt = state_reg.nmi_cnt + 3'd1;
            end
        end else begin
            state_next.nmi_cnt = 3'd0;
        end

        // standby entry on request
        if (standby_req_in) begin
            state_next.standby = 1'b1;
        end

        // first cycle after reset loads the restart address
        if (state_reg.boot) begin
            state_next.fetch = cpu_bus_pkg::RESET_ADDR;
            state_next.fload = 1'b1;
        end

        // interrupts decided in the last clock of an instruction
        if (instr_last_clk_in || state_reg.standby) begin
            if (state_reg.nmi_pend) begin
                // a request latched in this same clock survives the clear
                state_next.nmi_pend = state_reg.nmi_sync[1]
                    && state_reg.nmi_cnt == 3'(cpu_bus_pkg::NMI_HOLD_CLKS - 1);
                state_next.nmi_take = 1'b1;
                state_next.fetch    = cpu_bus_pkg::NMI_VEC_ADDR;
                state_next.fload    = 1'b1;
                state_next.standby  = 1'b0;
            end else if (state_reg.int_sync[1] && irq_enable_flag_in
                         && !state_reg.ack_cyc) begin
                state_next.int_take = 1'b1;
                state_next.ack_cyc  = 1'b1;
                state_next.standby  = 1'b0;
            end
        end

        // hold granted only between transfers, even inside acknowledge
        if (state_reg.phase == cpu_bus_pkg::PH_IDLE) begin
            state_next.hold = state_reg.hold_sync[1];
        end

        // bus phase sequencer
        case (state_reg.phase)
            cpu_bus_pkg::PH_IDLE: begin
                if (!state_reg.hold && !state_reg.hold_sync[1]) begin
                    if (state_reg.ack_cyc && state_reg.int_take == 1'b0
                        && !state_next.int_take) begin
                        state_next.phase  = cpu_bus_pkg::PH_ADDRESS;
                        state_next.write  = 1'b0;
                        state_next.wide   = 1'b0;
                        state_next.second = 1'b0;
                    end else if (req_in.valid && !state_reg.ack_cyc) begin
                        state_next.phase  = cpu_bus_pkg::PH_ADDRESS;
                        state_next.write  = req_in.write;
                        state_next.wide   = req_in.wide;
                        state_next.addr   = req_in.addr;
                        state_next.wdata  = req_in.wdata;
                        state_next.second = 1'b0;
                    end
                end
            end
            cpu_bus_pkg::PH_ADDRESS: begin
                state_next.phase = cpu_bus_pkg::PH_DATA_TWO;
            end
            cpu_bus_pkg::PH_DATA_TWO: begin
                state_next.phase = cpu_bus_pkg::PH_DATA_THREE;
            end
            cpu_bus_pkg::PH_DATA_THREE, cpu_bus_pkg::PH_WAIT: begin
                if (state_reg.rdy_sync[1]) begin
                    state_next.phase = cpu_bus_pkg::PH_DATA_FOUR;
                    if (state_reg.ack_cyc) begin
                        state_next.vector = addr_data_low_bus_in;
                    end else if (!state_reg.write) begin
                        if (state_reg.second) begin
                            state_next.rdata[15:8] = addr_data_low_bus_in;
                        end else begin
                            state_next.rdata[7:0] = addr_data_low_bus_in;
                        end
                    end
                end else begin
                    state_next.phase = cpu_bus_pkg::PH_WAIT;
                end
            end
            cpu_bus_pkg::PH_DATA_FOUR: begin
                if (state_reg.wide && !state_reg.second) begin
                    state_next.second = 1'b1;
                    state_next.addr   = state_reg.addr + 20'd1;
                    state_next.phase  = cpu_bus_pkg::PH_ADDRESS;
                end else begin
                    state_next.phase   = cpu_bus_pkg::PH_IDLE;
                    state_next.ack_cyc = 1'b0;
                    state_next.done    = !state_reg.ack_cyc;
                end
            end
            default: begin
                state_next.phase = cpu_bus_pkg::PH_IDLE;
            end
        endcase

        // acknowledge pin low through the acknowledge cycle, small-scale mode only
        state_next.ack_n = !(state_next.ack_cyc && state_reg.sel_sync[1]
                           && state_next.phase != cpu_bus_pkg::PH_IDLE);

        // pin drive for the next cycle
        state_next.mid_out = state_next.addr[15:8];
        state_next.mid_oe  = !state_next.hold;
        state_next.low_oe  = 1'b0;
        state_next.low_out = cpu_bus_pkg::BUS_IDLE;
        if (!state_next.hold && !state_next.ack_cyc) begin
            if (state_next.phase == cpu_bus_pkg::PH_ADDRESS) begin
                state_next.low_oe  = 1'b1;
                state_next.low_out = state_next.addr[7:0];
            end else if (state_next.write
                         && state_next.phase != cpu_bus_pkg::PH_IDLE) begin
                state_next.low_oe  = 1'b1;
                state_next.low_out = pick_byte(state_next.wdata, state_next.second);
            end
        end
    end

    // ----------------------------------------------------------------
    // registers; reset overrides all activity
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg       <= '0;
            state_reg.phase <= cpu_bus_pkg::PH_IDLE;
            state_reg.ack_n <= 1'b1;
            state_reg.boot  <= 1'b1;
            state_reg.mid_oe <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_done_out             = state_reg.done;
    assign rdata_out                = state_reg.rdata;
    assign nmi_take_out             = state_reg.nmi_take;
    assign int_take_out             = state_reg.int_take;
    assign int_vector_out           = state_reg.vector;
    assign fetch_addr_out           = state_reg.fetch;
    assign fetch_load_out           = state_reg.fload;
    assign standby_out              = state_reg.standby;
    assign addr_data_low_bus_out    = state_reg.low_out;
    assign addr_data_low_bus_oe_out = state_reg.low_oe;
    assign addr_mid_byte_out        = state_reg.mid_out;
    assign addr_mid_byte_oe_out     = state_reg.mid_oe;
    assign ctrl_oe_out              = state_reg.mid_oe;
    assign write_out                = state_reg.write;
    assign bus_hold_grant_out       = state_reg.hold;
    assign irq_ack_n_out            = state_reg.ack_n;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_addr_low;
        @(posedge clock_in) disable iff (reset_in)
        (state_reg.phase == cpu_bus_pkg::PH_ADDRESS && !state_reg.ack_cyc)
            |-> (state_reg.low_oe && state_reg.low_out == state_reg.addr[7:0]);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("low address missing");

    property p_mid_float;
        @(posedge clock_in) disable iff (reset_in)
        state_reg.hold |-> (!state_reg.mid_oe && !state_reg.low_oe);
    endproperty
    a_mid_float: assert property (p_mid_float) else $error("bus driven in hold");

    property p_ack_float;
        @(posedge clock_in) disable iff (reset_in)
        !state_reg.ack_n |-> !state_reg.low_oe;
    endproperty
    a_ack_float: assert property (p_ack_float) else $error("bus driven in ack");

    property p_wait;
        @(posedge clock_in) disable iff (reset_in)
        (state_reg.phase == cpu_bus_pkg::PH_DATA_THREE && !state_reg.rdy_sync[1])
            |=> state_reg.phase == cpu_bus_pkg::PH_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not inserted");

    property p_go;
        @(posedge clock_in) disable iff (reset_in)
        (state_reg.phase == cpu_bus_pkg::PH_WAIT && state_reg.rdy_sync[1])
            |=> state_reg.phase == cpu_bus_pkg::PH_DATA_FOUR;
    endproperty
    a_go: assert property (p_go) else $error("extra wait state");

    property p_nmi_vec;
        @(posedge clock_in) disable iff (reset_in)
        state_reg.nmi_take |-> (state_reg.fetch == cpu_bus_pkg::NMI_VEC_ADDR
                                && !state_reg.int_take && !state_reg.standby);
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi service wrong");

    property p_int_en;
        @(posedge clock_in) disable iff (reset_in)
        state_reg.int_take |-> $past(irq_enable_flag_in) && $past(state_reg.int_sync[1]);
    endproperty
    a_int_en: assert property (p_int_en) else $error("int taken while masked");

    property p_nmi_five;
        @(posedge clock_in) disable iff (reset_in)
        $rose(state_reg.nmi_sync[1]) ##1 state_reg.nmi_sync[1] [*4]
            |=> state_reg.nmi_pend || state_reg.nmi_take;
    endproperty
    a_nmi_five: assert property (p_nmi_five) else $error("nmi not latched");

    property p_wide;
        @(posedge clock_in) disable iff (reset_in)
        (state_reg.phase == cpu_bus_pkg::PH_DATA_FOUR && state_reg.wide && !state_reg.second)
            |=> state_reg.second && state_reg.phase == cpu_bus_pkg::PH_ADDRESS;
    endproperty
    a_wide: assert property (p_wide) else $error("high byte skipped");

    c_wait: cover property (@(posedge clock_in) state_reg.phase == cpu_bus_pkg::PH_WAIT);
    c_nmi:  cover property (@(posedge clock_in) state_reg.nmi_take);
    c_int:  cover property (@(posedge clock_in) !state_reg.ack_n);
    c_hold: cover property (@(posedge clock_in) state_reg.hold);

endmodule

// ---- rtl/cpu_bus_pkg.sv ----
package cpu_bus_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;     // system clock period
    localparam int NMI_HOLD_CLKS = 5;       // edge must stand this many clocks
    localparam int NMI_VECTOR    = 2;       // vector number for non-maskable
    localparam int VECTOR_BYTES  = 4;       // bytes per vector table entry

    // ----------------------------------------------------------------
    // addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [19:0] RESET_ADDR   = 20'hffff0;   // first fetch after reset
    localparam logic [19:0] NMI_VEC_ADDR = 20'h00008;   // NMI_VECTOR * VECTOR_BYTES
    localparam logic [7:0]  BUS_IDLE     = 8'h00;        // idle low-bus value

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDRESS,
        PH_DATA_TWO,
        PH_DATA_THREE,
        PH_WAIT,
        PH_DATA_FOUR
    } phase_t;

    // core request towards the bus unit
    typedef struct packed {
        logic        valid;    // start a transfer
        logic        write;    // 1 write, 0 read
        logic        wide;     // 16-bit operand
        logic [19:0] addr;     // physical address
        logic [15:0] wdata;    // write operand
    } bus_req_t;

    // data-and-enable pin group for the low bus
    typedef struct packed {
        logic [7:0] dout;
        logic       oe;
    } low_bus_drive_t;

endpackage

// ---- test/bus_target_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far-side memory, wait generator and interrupt controller
// ----------------------------------------------------------------
module bus_target_model (
    // clock
    input  wire logic       clock_in,
    // pins seen from the block
    input  wire logic [7:0] low_bus_in,
    input  wire logic       low_oe_in,
    input  wire logic [7:0] mid_in,
    input  wire logic       ack_n_in,
    // scenario settings
    input  wire logic [3:0] waits_in,
    input  wire logic [7:0] vector_in,
    // answers and observations
    output logic [7:0]      low_bus_out,
    output logic            ready_out,
    output logic [7:0]      addr_seen_out,
    output logic [7:0]      mid_seen_out,
    output logic [7:0]      data_seen_out
);
    logic       oe_last_reg = 1'b0;  // bus enable one clock ago
    logic [3:0] wait_reg    = 4'h0;  // wait clocks still to go

    // capture address as the block starts driving, count waits down
    always_ff @(posedge clock_in) begin
        oe_last_reg <= low_oe_in;
        if (low_oe_in && !oe_last_reg) begin
            addr_seen_out <= low_bus_in;
            mid_seen_out  <= mid_in;
            wait_reg      <= waits_in;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end
        if (low_oe_in) begin
            data_seen_out <= low_bus_in;
        end
    end

    // ready moves only just after an edge, low while waits remain; it drops as
    // the address appears so the block's two-flop sampler sees it by phase three
    assign ready_out = (wait_reg == 4'h0)
                       && !(low_oe_in && !oe_last_reg && waits_in != 4'h0);

    // vector in acknowledge, inverse while block drives, else read byte
    always_comb begin
        if (!ack_n_in) begin
            low_bus_out = vector_in;
        end else if (low_oe_in) begin
            low_bus_out = ~low_bus_in;
        end else begin
            low_bus_out = addr_seen_out ^ 8'ha5;
        end
    end
endmodule

// ---- test/test_cpu_bus_interrupt_interface.sv ----
`timescale 1ns/100ps
module test_cpu_bus_interrupt_interface;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic                  clock_in = 1'b0;
    logic                  reset_in = 1'b1;
    cpu_bus_pkg::bus_req_t req      = '0;
    logic last_clk = 1'b0, ie = 1'b0, stby_req = 1'b0, nmi = 1'b0, int_req = 1'b0;
    logic hold_req = 1'b0, done, nmi_take, int_take, fload, stby, loe, moe, coe;
    logic scale    = 1'b1;  // scale select, fixed while out of reset
    logic wr, ready, grant, ack_n, seen_nmi, seen_int, seen_ack, ack_oe;
    logic [3:0]  waits = 4'h0;
    logic [7:0]  vec, lb_in, lb_out, mid, addr_seen, mid_seen, data_seen;
    logic [15:0] rdata;
    logic [19:0] faddr, load_addr;
    int          err_total = 0, num_checks = 0;

    // 10 MHz clock
    initial begin
        forever #50 clock_in = ~clock_in;
    end

    cpu_bus_interrupt_interface dut_u (
        .clock_in(clock_in), .reset_in(reset_in), .req_in(req),
        .instr_last_clk_in(last_clk), .irq_enable_flag_in(ie), .standby_req_in(stby_req),
        .req_done_out(done), .rdata_out(rdata), .nmi_take_out(nmi_take),
        .int_take_out(int_take), .int_vector_out(vec), .fetch_addr_out(faddr),
        .fetch_load_out(fload), .standby_out(stby), .addr_data_low_bus_in(lb_in),
        .addr_data_low_bus_out(lb_out), .addr_data_low_bus_oe_out(loe),
        .addr_mid_byte_out(mid), .addr_mid_byte_oe_out(moe), .ctrl_oe_out(coe),
        .write_out(wr), .ready_in(ready), .nmi_in(nmi), .int_in(int_req),
        .bus_hold_req_in(hold_req), .bus_hold_grant_out(grant), .irq_ack_n_out(ack_n),
        .system_scale_select_in(scale));

    bus_target_model model_u (
        .clock_in(clock_in), .low_bus_in(lb_out), .low_oe_in(loe), .mid_in(mid),
        .ack_n_in(ack_n), .waits_in(waits), .vector_in(8'h4c), .low_bus_out(lb_in),
        .ready_out(ready), .addr_seen_out(addr_seen), .mid_seen_out(mid_seen),
        .data_seen_out(data_seen));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // note pulses and acknowledge over n clocks, sampled at falling edges
    task automatic watch(input int n);
        {seen_nmi, seen_int, seen_ack, ack_oe} = 4'h0;
        load_addr = 20'hfffff;
        repeat (n) begin
            @(negedge clock_in);
            last_clk = 1'b0;  // a last-clock pulse spans one rising edge
            seen_nmi |= (nmi_take === 1'b1);
            seen_int |= (int_take === 1'b1);
            if (ack_n === 1'b0) begin
                seen_ack = 1'b1;
                ack_oe |= (loe !== 1'b0);
            end
            if (fload === 1'b1) begin
                load_addr = faddr;
            end
        end
    endtask

    // one transfer, valid held until done
    task automatic xfer(input logic w, d, input logic [19:0] a, input logic [15:0] v,
                        output int lat);
        @(negedge clock_in);
        req = '{1'b1, w, d, a, v};
        lat = 0;
        do begin
            @(posedge clock_in);
            #1;
            lat++;
        end while (done !== 1'b1 && lat < 60);
        cmp("done seen", 20'h00001, done);
        @(negedge clock_in);
        req.valid = 1'b0;
    endtask

    task automatic nmi_pulse;
        @(negedge clock_in);
        nmi = 1'b1;
        repeat (cpu_bus_pkg::NMI_HOLD_CLKS) @(negedge clock_in);
        nmi = 1'b0;
    endtask

    // raised here, lowered by the watch that follows
    task automatic last_pulse;
        @(negedge clock_in);
        last_clk = 1'b1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input int n, input logic s);
        @(negedge clock_in);
        reset_in = 1'b1;
        scale = s;
        req.valid = 1'b0;
        repeat (n) @(negedge clock_in);
        cmp("reset low oe", 20'h00000, loe);
        cmp("reset ack", 20'h00001, ack_n);
        reset_in = 1'b0;
        @(posedge clock_in);
        #1;
        cmp("reset load", 20'h00001, fload);
        cmp("reset addr", cpu_bus_pkg::RESET_ADDR, faddr);
        $display("test reset done");
    endtask

    task automatic t_bus;
        int l0, lw;
        xfer(1'b1, 1'b0, 20'h3c5a7, 16'h00e1, l0);
        cmp("low address", 20'h000a7, addr_seen);
        cmp("mid address", 20'h000c5, mid_seen);
        cmp("write data", 20'h000e1, data_seen);
        cmp("latency", 20'h00005, 20'(l0));
        xfer(1'b1, 1'b1, 20'h04410, 16'hbeef, lw);
        cmp("high byte last", 20'h000be, data_seen);
        xfer(1'b0, 1'b1, 20'h0127f, 16'h0000, lw);
        cmp("wide read", {4'h0, 8'h80 ^ 8'ha5, 8'h7f ^ 8'ha5}, rdata);
        cmp("second mid", 20'h00012, mid_seen);
        waits = 4'h3;
        xfer(1'b0, 1'b0, 20'h00033, 16'h0000, lw);
        waits = 4'h0;
        cmp("wait stretch", 20'h00001, 20'(lw > l0));
        cmp("read byte", 20'h00096, rdata[7:0]);
        $display("test bus done");
    endtask

    task automatic t_hold;
        @(negedge clock_in);
        hold_req = 1'b1;
        watch(10);
        cmp("grant", 20'h00001, grant);
        cmp("mid float", 20'h00000, moe);
        cmp("low float", 20'h00000, loe);
        cmp("ctrl float", 20'h00000, coe);
        @(negedge clock_in);
        hold_req = 1'b0;
        watch(10);
        cmp("grant drop", 20'h00000, grant);
        $display("test hold done");
    endtask

    task automatic t_irq;
        nmi_pulse();
        watch(8);
        cmp("nmi waits", 20'h00000, seen_nmi);
        int_req = 1'b1;
        last_pulse();
        watch(10);
        cmp("nmi taken", 20'h00001, seen_nmi);
        cmp("nmi vector", cpu_bus_pkg::NMI_VEC_ADDR, load_addr);
        last_pulse();
        watch(8);
        cmp("masked", 20'h00000, seen_int);
        ie = 1'b1;
        watch(6);
        cmp("int level", 20'h00000, seen_int);
        last_pulse();
        watch(12);
        cmp("int taken", 20'h00001, seen_int);
        cmp("ack low", 20'h00001, seen_ack);
        cmp("ack float", 20'h00000, ack_oe);
        cmp("vector", 20'h0004c, vec);
        nmi_pulse();
        watch(2);
        last_pulse();
        watch(12);
        cmp("nmi first", 20'h00001, seen_nmi);
        cmp("int refused", 20'h00000, seen_int);
        int_req = 1'b0;
        $display("test interrupts done");
    endtask

    task automatic t_standby;
        @(negedge clock_in);
        stby_req = 1'b1;
        @(negedge clock_in);
        stby_req = 1'b0;
        watch(4);
        cmp("standby", 20'h00001, stby);
        nmi_pulse();
        watch(12);
        cmp("standby left", 20'h00000, stby);
        $display("test standby done");
    endtask

    // large-scale mode: interrupt still taken, acknowledge pin stays high
    task automatic t_large;
        int_req = 1'b1;
        watch(2);
        last_pulse();
        watch(12);
        cmp("large int", 20'h00001, seen_int);
        cmp("large no ack", 20'h00000, seen_ack);
        int_req = 1'b0;
        $display("test large scale done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence, with a reset in mid-transfer
    initial begin
        t_reset(16, 1'b1);
        t_bus();
        t_hold();
        t_irq();
        t_standby();
        @(negedge clock_in);
        req = '{1'b1, 1'b0, 1'b1, 20'h00100, 16'h0000};
        repeat (2) @(negedge clock_in);
        t_reset(3, 1'b0);
        t_bus();
        t_large();
        complete_run();
    end

    // watchdog
    initial begin
        #(100 * 3000);
        err_total++;
        complete_run();
    end
endmodule
